//--- design/drb_diag_record_builder.sv
// drb_diag_record_builder: diagnostic record builder of the I/O and
// function channels; tracks errors, calls the diagnostic handler,
// writes buffer entries and serves record reads.
// assumes software on the same clk and the module reset; fault inputs
// are pins and are synchronised here, all other inputs are synchronous.
//
// Functional notes
// - every diagnostic handler call writes one buffer entry with cause and module address.
// - with the diagnostic interrupt disabled the latest event still stays readable.
// - with the diagnostic function on, the basic record is loaded into local dword 8 on the same edge the call starts.
// - the read service also returns the extended record set 1.
// - after the handler exits the local dword 8 copy is dropped.
// - summary bit 0 flags lost interrupts, missing supplies and output overload.
// - summary bit 1 flags missing supplies and output overload.
// - summary bits 2, 3, 4 flag external, channel and external supply errors; 7:5 are zero.
// - byte 1 bits 3:0 hold the module class, bits 7:5 read zero.
// - byte 1 bit 4 flags channel information for lost interrupt, supply or overload.
// - byte 2 bit 4 flags a missing internal supply, all other bits are zero.
// - incoming byte 3 bit 6 flags a lost process interrupt, others are zero.
// - an outgoing message goes out only while the interrupt enable is still on.
// - the basic record layout is the same in every channel mode.
// - record set 1 is the four basic bytes plus twelve module bytes.
// - a repeat process event while its handler runs raises a diagnostic interrupt.
`include "drb_map.svh"
module drb_diag_record_builder
   import drb_pkg::*;
#(
   parameter int       NUM_EVENTS    = 32,
   parameter int       EVENT_ID_W    = 5,
   parameter logic [6:0] CHAN_TYPE   = 7'h70,
   parameter logic [7:0] DIAG_BITS   = 8'h08,
   parameter logic [7:0] NUM_CHANNELS = 8'h08
) (
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   // configuration
   input  wire logic                  diag_int_enable,
   input  wire logic                  diag_function_enable,
   input  wire logic                  function_module,
   input  wire logic                  more_chan_types,
   input  wire logic [15:0]           module_address,
   // fault pins
   input  wire logic                  input_supply_group_missing,
   input  wire logic                  output_supply_missing,
   input  wire logic                  output_overload,
   input  wire logic                  external_error,
   input  wire logic                  channel_error,
   input  wire logic                  external_supply_missing,
   // process events
   input  wire logic                  proc_event,
   input  wire logic [EVENT_ID_W-1:0] proc_event_id,
   input  wire logic                  process_event_handler_busy,
   // diagnostic handler
   output logic                       diag_call_ff,
   output logic                       diag_outgoing_ff,
   output logic [31:0]                diag_local_dword8_ff,
   input  wire logic                  diag_handler_done,
   // diagnostic buffer
   output logic                       buf_entry_valid_ff,
   output logic                       buf_entry_outgoing_ff,
   output logic [7:0]                 buf_entry_cause_ff,
   output logic [15:0]                buf_entry_addr_ff,
   // record read service
   input  wire logic                  rd_req,
   input  wire logic                  rd_set,
   input  wire logic [3:0]            rd_index,
   output logic                       rd_valid_ff,
   output logic [7:0]                 rd_data_ff
);
   localparam int NUM_FAULTS = 6;

   // reset release
   logic rst_s1_ff;
   logic rst_s2_ff;
   logic rst_n;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_ff <= 1'b0;
         rst_s2_ff <= 1'b0;
      end else begin
         rst_s1_ff <= 1'b1;
         rst_s2_ff <= rst_s1_ff;
      end
   end
   assign rst_n = rst_s2_ff;

   // fault pins
   logic [NUM_FAULTS-1:0] fault_pins;
   logic [NUM_FAULTS-1:0] fault_lvl;

   assign fault_pins = {external_supply_missing, channel_error,
                        external_error, output_overload,
                        output_supply_missing, input_supply_group_missing};

   drb_sync #(
      .WIDTH (NUM_FAULTS)
   ) u_fault_sync (
      .clk       (clk),
      .reset_n   (rst_n),
      .async_in  (fault_pins),
      .level_out (fault_lvl)
   );

   // process event supervision
   logic [NUM_EVENTS-1:0] serving_ff;
   logic [NUM_EVENTS-1:0] lost_bits_ff;
   logic                  busy_prev_ff;
   logic [NUM_EVENTS-1:0] event_onehot;
   logic                  handler_end;
   logic [NUM_EVENTS-1:0] lost_set;
   logic [NUM_EVENTS-1:0] nxt_serving;
   logic [NUM_EVENTS-1:0] nxt_lost_bits;

   assign event_onehot = proc_event ?
      (NUM_EVENTS'(1) << proc_event_id) : '0;
   assign handler_end  = busy_prev_ff & ~process_event_handler_busy;
   assign lost_set     = event_onehot & serving_ff &
                         {NUM_EVENTS{process_event_handler_busy}};
   // the handler finishing releases served events; a new one still lands
   assign nxt_serving  = (handler_end ? '0 : serving_ff) | event_onehot;
   assign nxt_lost_bits = (handler_end ? '0 : lost_bits_ff) | lost_set;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         serving_ff   <= '0;
         lost_bits_ff <= '0;
         busy_prev_ff <= 1'b0;
      end else begin
         serving_ff   <= nxt_serving;
         lost_bits_ff <= nxt_lost_bits;
         busy_prev_ff <= process_event_handler_busy;
      end
   end

   // error condition tracking
   logic [NUM_FAULTS:0] cond;
   logic [NUM_FAULTS:0] cond_prev_ff;
   logic                new_err;
   logic                all_clear;
   logic [NUM_FAULTS:0] fmt_cond;
   logic [3:0]          class_code;
   logic [31:0]         fmt_record;

   assign cond       = {|lost_bits_ff, fault_lvl};
   assign new_err    = |(cond & ~cond_prev_ff);
   assign all_clear  = ~|cond & |cond_prev_ff;
   // the outgoing record describes the errors that just went away
   assign fmt_cond   = all_clear ? cond_prev_ff : cond;
   assign class_code = function_module ? `DRB_CLASS_FUNCTION
                                       : `DRB_CLASS_DIGITAL;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_prev_ff <= '0;
      end else begin
         cond_prev_ff <= cond;
      end
   end

   drb_record_format u_format (
      .class_code   (class_code),
      .lost         (fmt_cond[6]),
      .in_sup_miss  (fmt_cond[0]),
      .out_sup_miss (fmt_cond[1]),
      .overload     (fmt_cond[2]),
      .ext_err      (fmt_cond[3]),
      .chan_err     (fmt_cond[4]),
      .ext_sup_miss (fmt_cond[5]),
      .outgoing     (all_clear),
      .record       (fmt_record)
   );

   // latest event, kept whether or not the interrupt is enabled
   logic [31:0]           rec_last_ff;
   logic [NUM_EVENTS-1:0] lost_last_ff;
   logic                  any_event;

   assign any_event = new_err | all_clear;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rec_last_ff  <= `DRB_RST_RECORD;
         lost_last_ff <= '0;
      end else if (any_event) begin
         rec_last_ff  <= fmt_record;
         lost_last_ff <= all_clear ? '0 : lost_bits_ff;
      end
   end

   // pending handler calls
   logic        in_pend_ff;
   logic        out_pend_ff;
   logic [31:0] in_rec_ff;
   logic [31:0] out_rec_ff;
   logic        launch_in;
   logic        launch_out;
   logic        in_set;
   logic        out_set;
   logic        nxt_in_pend;
   logic        nxt_out_pend;
   drb_state_type state_ff;
   drb_state_type nxt_state;

   assign in_set     = new_err & diag_int_enable;
   assign out_set    = all_clear & diag_int_enable;
   // incoming calls go first; disabling drops what still waits
   assign launch_in  = (state_ff == st_idle) & in_pend_ff &
                       diag_int_enable;
   assign launch_out = (state_ff == st_idle) & ~in_pend_ff &
                       out_pend_ff & diag_int_enable;
   // a new event in the launch cycle survives the launch
   assign nxt_in_pend  = (in_pend_ff & ~launch_in & diag_int_enable) |
                         in_set;
   assign nxt_out_pend = (out_pend_ff & ~launch_out & diag_int_enable) |
                         out_set;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_pend_ff  <= 1'b0;
         out_pend_ff <= 1'b0;
         in_rec_ff   <= `DRB_RST_RECORD;
         out_rec_ff  <= `DRB_RST_RECORD;
      end else begin
         in_pend_ff  <= nxt_in_pend;
         out_pend_ff <= nxt_out_pend;
         if (in_set) begin
            in_rec_ff <= fmt_record;
         end
         if (out_set) begin
            out_rec_ff <= fmt_record;
         end
      end
   end

   // handler sequencer
   logic        launch;
   logic [31:0] launch_rec;
   logic        call_end;

   assign launch     = launch_in | launch_out;
   assign launch_rec = launch_in ? in_rec_ff : out_rec_ff;
   assign call_end   = (state_ff == st_call) & diag_handler_done;

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         st_idle: begin
            if (launch) begin
               nxt_state = st_call;
            end
         end
         st_call: begin
            if (diag_handler_done) begin
               nxt_state = st_idle;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= st_idle;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // handler outputs
   logic [31:0] nxt_dword8;

   // record in dword 8 at call
   assign nxt_dword8 = (launch & diag_function_enable) ? launch_rec :
                       call_end ? `DRB_RST_RECORD : diag_local_dword8_ff;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         diag_call_ff         <= 1'b0;
         diag_outgoing_ff     <= 1'b0;
         diag_local_dword8_ff <= `DRB_RST_RECORD;
      end else begin
         diag_local_dword8_ff <= nxt_dword8;
         if (launch) begin
            diag_call_ff     <= 1'b1;
            diag_outgoing_ff <= launch_out;
         end else if (call_end) begin
            diag_call_ff     <= 1'b0;
         end
      end
   end

   // diagnostic buffer entry
   // one entry per call
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buf_entry_valid_ff    <= 1'b0;
         buf_entry_outgoing_ff <= 1'b0;
         buf_entry_cause_ff    <= `DRB_RST_BYTE;
         buf_entry_addr_ff     <= 16'h0000;
      end else begin
         buf_entry_valid_ff <= launch;
         if (launch) begin
            buf_entry_outgoing_ff <= launch_out;
            buf_entry_cause_ff    <= launch_rec[7:0];
            buf_entry_addr_ff     <= module_address;
         end
      end
   end

   // extended record
   logic [3:0]                 grp_err;
   logic [`DRB_REC1_BYTES*8-1:0] rec1_vec;
   logic [7:0]                 rec1_byte;
   logic [7:0]                 rec0_byte;
   logic [7:0]                 rd_byte;
   logic [NUM_EVENTS-1:0]      lost_word;

   // group error flags, one per byte of lost events
   for (genvar g = 0; g < 4; g++) begin : g_grp
      assign grp_err[g] = |lost_word[g*8 +: 8];
   end

   assign lost_word = lost_last_ff;

   // four basic bytes then twelve module bytes
   assign rec1_vec = {32'h0000_0000,
                      lost_word,
                      {4'h0, grp_err},
                      NUM_CHANNELS,
                      DIAG_BITS,
                      {more_chan_types, CHAN_TYPE},
                      rec_last_ff};

   assign rec1_byte = rec1_vec[rd_index*8 +: 8];
   // basic set reads zero beyond its four bytes
   assign rec0_byte = (rd_index < 4'(`DRB_REC0_BYTES)) ?
                      rec_last_ff[rd_index[1:0]*8 +: 8] : `DRB_RST_BYTE;
   assign rd_byte   = (rd_set == `DRB_SET_EXTENDED) ? rec1_byte
                                                    : rec0_byte;

   // record read service
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_valid_ff <= 1'b0;
         rd_data_ff  <= `DRB_RST_BYTE;
      end else begin
         rd_valid_ff <= rd_req;
         if (rd_req) begin
            rd_data_ff <= rd_byte;
         end
      end
   end
endmodule

//--- design/drb_map.svh
// drb_map.svh: offsets, bit positions, codes and reset values of the
// diagnostic record builder; assumes nothing beyond the preprocessor
`ifndef DRB_MAP_SVH
`define DRB_MAP_SVH

// byte index of each record byte; byte 0 sits in bits 7:0 of the word
`define DRB_OFS_SUMMARY        4'h0
`define DRB_OFS_CLASS_INFO     4'h1
`define DRB_OFS_SUPPLY_FLAG    4'h2
`define DRB_OFS_LOST_FLAG      4'h3
`define DRB_OFS_EXT_LOST_BASE  4'h8

// bit positions inside the 32-bit basic record
`define DRB_B0_MOD_FAIL        0
`define DRB_B0_INT_ERR         1
`define DRB_B0_EXT_ERR         2
`define DRB_B0_CHAN_ERR        3
`define DRB_B0_EXT_SUP_MISS    4
`define DRB_B1_CLASS_LSB       8
`define DRB_B1_CHAN_INFO       12
`define DRB_B2_INT_SUP_MISS    20
`define DRB_B3_LOST            30

// module class codes
`define DRB_CLASS_DIGITAL      4'hF
`define DRB_CLASS_FUNCTION     4'h8

// record sizes in bytes
`define DRB_REC0_BYTES         4
`define DRB_REC1_BYTES         16

// record set selectors of the read service
`define DRB_SET_BASIC          1'h0
`define DRB_SET_EXTENDED       1'h1

// reset values
`define DRB_RST_RECORD         32'h0000_0000
`define DRB_RST_BYTE           8'h00

`endif

//--- design/drb_pkg.sv
// drb_pkg: types shared by the diagnostic record builder files
// assumes drb_map.svh is on the include path
package drb_pkg;
   // sequencer of the diagnostic handler calls
   typedef enum logic [0:0] {
      st_idle,
      st_call
   } drb_state_type;

   typedef logic [31:0] drb_record_type;
endpackage

//--- design/drb_sync.sv
// drb_sync: three-flop synchroniser for asynchronous levels
// assumes reset_n is already synchronous to clk
module drb_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] level_out
);
   logic [WIDTH-1:0] s1_ff;
   logic [WIDTH-1:0] s2_ff;
   logic [WIDTH-1:0] s3_ff;
   logic [WIDTH-1:0] agree;
   logic [WIDTH-1:0] nxt_level;

   // a bit only moves once stages two and three agree
   assign agree     = ~(s2_ff ^ s3_ff);
   assign nxt_level = (agree & s3_ff) | (~agree & level_out);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_ff     <= '0;
         s2_ff     <= '0;
         s3_ff     <= '0;
         level_out <= '0;
      end else begin
         s1_ff     <= async_in;
         s2_ff     <= s1_ff;
         s3_ff     <= s2_ff;
         level_out <= nxt_level;
      end
   end
endmodule

//--- design/drb_record_format.sv
// drb_record_format: builds the four bytes of the basic record
// assumes error levels are already synchronous to clk
`include "drb_map.svh"
module drb_record_format (
   // module class, error causes and direction
   input  wire logic [3:0] class_code,
   input  wire logic       lost,
   input  wire logic       in_sup_miss,
   input  wire logic       out_sup_miss,
   input  wire logic       overload,
   input  wire logic       ext_err,
   input  wire logic       chan_err,
   input  wire logic       ext_sup_miss,
   input  wire logic       outgoing,
   // record
   output logic [31:0]     record
);
   logic sup_miss;
   logic internal;
   logic chan_info;

   assign sup_miss  = in_sup_miss | out_sup_miss;
   assign internal  = sup_miss | overload;
   assign chan_info = lost | internal;

   always_comb begin
      record = `DRB_RST_RECORD;
      record[`DRB_B0_MOD_FAIL]     = lost | internal;
      record[`DRB_B0_INT_ERR]      = internal;
      record[`DRB_B0_EXT_ERR]      = ext_err;
      record[`DRB_B0_CHAN_ERR]     = chan_err;
      record[`DRB_B0_EXT_SUP_MISS] = ext_sup_miss;
      record[`DRB_B1_CLASS_LSB +: 4] = class_code;
      record[`DRB_B1_CHAN_INFO]    = chan_info;
      record[`DRB_B2_INT_SUP_MISS] = sup_miss;
      record[`DRB_B3_LOST]         = lost & ~outgoing;
   end
endmodule

//--- tb/drb_diag_record_builder_assertions.sv
// drb_diag_record_builder_assertions: port-level checks of the builder
// assumes one clk domain; bound to every instance of the top module
module drb_record_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset_n,
   // configuration
   input wire logic        diag_int_enable,
   input wire logic        diag_function_enable,
   input wire logic        function_module,
   input wire logic [15:0] module_address,
   // diagnostic handler and buffer
   input wire logic        diag_call_ff,
   input wire logic        diag_outgoing_ff,
   input wire logic [31:0] diag_local_dword8_ff,
   input wire logic        diag_handler_done,
   input wire logic        buf_entry_valid_ff,
   input wire logic [7:0]  buf_entry_cause_ff,
   input wire logic [15:0] buf_entry_addr_ff,
   // read service
   input wire logic        rd_req,
   input wire logic        rd_valid_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   wire logic launch;
   wire logic [31:0] rec;
   // a call only counts when the record was really loaded
   assign launch = diag_call_ff && buf_entry_valid_ff && diag_function_enable;
   assign rec = diag_local_dword8_ff;

   a_read_answer: assert property (rd_req |=> rd_valid_ff)
      else $error("read request got no answer");
   a_read_quiet: assert property (!rd_req |=> !rd_valid_ff)
      else $error("read answer without request");
   a_entry_per_call: assert property (
      buf_entry_valid_ff |-> $rose(diag_call_ff) ##1 !buf_entry_valid_ff)
      else $error("buffer entry not one pulse per call");
   a_entry_address: assert property (
      buf_entry_valid_ff |-> buf_entry_addr_ff == module_address)
      else $error("buffer entry address wrong");
   a_record_loaded: assert property (
      launch |-> rec[7:0] == buf_entry_cause_ff)
      else $error("local dword 8 not loaded at call");
   a_exit_clears: assert property (
      diag_call_ff && diag_handler_done |-> ##[1:2] !diag_call_ff && rec == 0)
      else $error("handler exit did not drop the record");
   a_fixed_zeros: assert property (
      launch |-> rec[7:5] == 0 && rec[15:13] == 0 && rec[19:16] == 0
      && rec[23:21] == 0 && rec[31] == 0 && rec[29:24] == 0)
      else $error("fixed zero bits set in record");
   a_class_code: assert property (
      launch |-> rec[11:8] == (function_module ? 4'h8 : 4'hF))
      else $error("module class wrong");
   a_failure_bits: assert property (
      launch |-> rec[12] == rec[0] && (!rec[1] || rec[0])
      && (diag_outgoing_ff || rec[0] == (rec[1] || rec[30])))
      else $error("failure or channel info bit wrong");
   a_supply_bit: assert property (launch && rec[20] |-> rec[1])
      else $error("internal supply flag without internal error");
   a_outgoing_byte3: assert property (
      launch && diag_outgoing_ff |-> rec[31:24] == 0)
      else $error("outgoing record byte 3 not zero");
   a_enable_gate: assert property (
      $rose(diag_call_ff) |-> $past(diag_int_enable))
      else $error("call launched while interrupt disabled");

   c_outgoing: cover property (launch && diag_outgoing_ff);
   c_lost: cover property (launch && rec[30]);
   c_read: cover property (rd_valid_ff);
endmodule

bind drb_diag_record_builder drb_record_checker i_chk (
   .clk(clk), .reset_n(reset_n), .diag_int_enable(diag_int_enable),
   .diag_function_enable(diag_function_enable),
   .function_module(function_module), .module_address(module_address),
   .diag_call_ff(diag_call_ff), .diag_outgoing_ff(diag_outgoing_ff),
   .diag_local_dword8_ff(diag_local_dword8_ff),
   .diag_handler_done(diag_handler_done),
   .buf_entry_valid_ff(buf_entry_valid_ff),
   .buf_entry_cause_ff(buf_entry_cause_ff),
   .buf_entry_addr_ff(buf_entry_addr_ff),
   .rd_req(rd_req), .rd_valid_ff(rd_valid_ff));

//--- tb/drb_diag_record_builder_tb.sv
// drb_diag_record_builder_tb: self-checking bench of the record builder
// assumes the design files and the checker are compiled before it
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   bad_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module drb_diag_record_builder_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, reset_n, ena, fm, more, pev, busy, done;
   logic        rd_req, rd_set, rd_valid_ff;
   logic [3:0]  rd_index;
   logic [5:0]  flt;
   logic [7:0]  rd_data_ff, cause;
   logic [15:0] addr;
   logic        call, outg, bval, bout;
   logic        dfe;
   logic [4:0]  pid;
   logic [31:0] dw8, r;
   int          bad_count, samples_checked, cycles, calls, n0;
   logic [7:0]  set1 [0:8] = '{8'h01, 8'h1F, 8'h00, 8'h40, 8'hF0, 8'h08,
                               8'h08, 8'h01, 8'h08};

   drb_diag_record_builder i_dut (
      .clk(clk), .reset_n(reset_n), .diag_int_enable(ena),
      .diag_function_enable(dfe), .function_module(fm),
      .more_chan_types(more), .module_address(16'h1234),
      .input_supply_group_missing(flt[0]), .output_supply_missing(flt[1]),
      .output_overload(flt[2]), .external_error(flt[3]),
      .channel_error(flt[4]), .external_supply_missing(flt[5]),
      .proc_event(pev), .proc_event_id(pid),
      .process_event_handler_busy(busy), .diag_call_ff(call),
      .diag_outgoing_ff(outg), .diag_local_dword8_ff(dw8),
      .diag_handler_done(done), .buf_entry_valid_ff(bval),
      .buf_entry_outgoing_ff(bout), .buf_entry_cause_ff(cause),
      .buf_entry_addr_ff(addr), .rd_req(rd_req), .rd_set(rd_set),
      .rd_index(rd_index), .rd_valid_ff(rd_valid_ff),
      .rd_data_ff(rd_data_ff));

   always #25 clk = ~clk;

   // the ceiling is more than twenty times the length of the sequence
   always @(posedge clk) begin
      cycles++;
      if (bval === 1'b1) calls++;
      if (cycles == 6000) begin
         bad_count++;
         close_out();
      end
   end

   task automatic close_out();
      if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic rd(input logic s, input logic [3:0] i, input logic [7:0] e);
      @(posedge clk);
      rd_req <= 1'b1;
      rd_set <= s;
      rd_index <= i;
      @(posedge clk);
      rd_req <= 1'b0;
      #1;
      `CHK(rd_valid_ff, 1'b1)
      `CHK(rd_data_ff, e)
   endtask

   // waits for one handler call, checks it, then lets the handler exit
   task automatic wait_call(input logic [31:0] e, input logic o);
      int n;
      n = 0;
      // the call pulse may be launched by the very edge this task starts on
      #1;
      while (bval !== 1'b1 && n < 30) begin
         @(posedge clk);
         #1;
         n++;
      end
      `CHK(bval, 1'b1)
      `CHK(cause, e[7:0])
      `CHK(addr, 16'h1234)
      `CHK({bout, outg}, {o, o})
      `CHK(dw8, e & {32{dfe}})
      @(posedge clk) done <= 1'b1;
      @(posedge clk) done <= 1'b0;
      @(posedge clk);
      #1;
      `CHK({call, dw8}, 33'h0)
   endtask

   task automatic pulse(input logic [4:0] id);
      @(posedge clk) begin
         pev <= 1'b1;
         pid <= id;
      end
      @(posedge clk) pev <= 1'b0;
   endtask

   function automatic logic [31:0] rec(input int k, input logic f);
      logic s, c;
      s = (k < 2);
      c = s || (k == 2);
      rec = {8'h00, 3'h0, s, 4'h0, 3'h0, c, f ? 4'h8 : 4'hF,
             3'h0, k == 5, k == 4, k == 3, c, c};
   endfunction

   initial begin
      clk = 0; reset_n = 0; ena = 1; fm = 0; more = 0; pev = 0;
      busy = 0; done = 0; rd_req = 0; rd_set = 0; rd_index = 0; flt = 0;
      dfe = 1; pid = 0;
      bad_count = 0; samples_checked = 0; cycles = 0; calls = 0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(1'b0, 4'h0, 8'h00);
      rd(1'b0, 4'h5, 8'h00);
      // each fault cause in turn, both module classes, in and out
      for (int k = 0; k < 6; k++) begin
         r = rec(k, k[0]);
         @(posedge clk);
         fm <= k[0];
         flt <= 6'h01 << k;
         wait_call(r, 1'b0);
         for (int i = 0; i < 4; i++) rd(1'b0, i[3:0], r[8*i+:8]);
         @(posedge clk) flt <= 6'h00;
         wait_call(r, 1'b1);
      end
      // disabled interrupt: no calls, latest record still readable
      @(posedge clk) ena <= 1'b0;
      fm <= 1'b0;
      n0 = calls;
      flt <= 6'h04;
      repeat (15) @(posedge clk);
      rd(1'b0, 4'h0, 8'h03);
      @(posedge clk) flt <= 6'h00;
      repeat (15) @(posedge clk);
      `CHK(calls, n0)
      @(posedge clk) ena <= 1'b1;
      more <= 1'b1;
      // repeated process event while its handler runs
      pulse(5'h03);
      @(posedge clk) busy <= 1'b1;
      // a different event id while busy is not a lost repeat
      pulse(5'h05);
      pulse(5'h03);
      pulse(5'h03);
      wait_call(32'h40001F01, 1'b0);
      for (int i = 0; i < 9; i++) rd(1'b1, i[3:0], set1[i]);
      rd(1'b1, 4'hC, 8'h00);
      rd(1'b1, 4'hF, 8'h00);
      // diagnostic function off: the call must leave dword 8 empty
      @(posedge clk) busy <= 1'b0;
      dfe <= 1'b0;
      wait_call(32'h00001F01, 1'b1);
      rd(1'b1, 4'h8, 8'h00);
      // second reset in mid-run clears the record
      @(posedge clk) reset_n <= 1'b0;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(1'b0, 4'h0, 8'h00);
      close_out();
   end
endmodule
